// file: fcc_originator.sv
`timescale 1ns/1ps
module fcc_originator #(
  parameter int TS_BYTES  = fcc_pkg::TS_BYTES,
  parameter int CLS_BYTES = fcc_pkg::CLS_BYTES,
  parameter int MAX_HOPS  = fcc_pkg::MAX_HOPS
) (
  // Clock and reset
  input  logic                    i_clk,
  input  logic                    i_reset,
  // Link
  fcc_link_if.origin              lnk,
  // Request to send
  input  logic                    i_start,
  input  logic [7:0]              i_node_id,
  input  logic [7:0]              i_flow_num,
  input  logic [8*TS_BYTES-1:0]   i_traffic_spec,
  input  logic                    i_bidir,
  input  logic [47:0]             i_rev_mac,
  input  logic [8*TS_BYTES-1:0]   i_rev_traffic_spec,
  input  logic [8*CLS_BYTES-1:0]  i_rev_cls,
  input  logic                    i_tunnel,
  input  logic [7:0]              i_endpoint_id,
  input  logic [7:0]              i_relay_cnt,
  input  logic [8*MAX_HOPS-1:0]   i_relays,
  output logic                    o_busy,
  // Confirm received
  output logic                    o_cnf_valid,
  output logic                    o_cnf_error,
  output logic                    o_cnf_match,
  output logic                    o_cnf_success,
  output logic [7:0]              o_cnf_node,
  output logic [7:0]              o_cnf_flow,
  output logic [7:0]              o_cnf_result,
  output logic                    o_cnf_bidir,
  output logic [7:0]              o_cnf_rev_flow,
  output logic                    o_cnf_tunnel,
  output logic [7:0]              o_cnf_hop_count,
  output logic [8*MAX_HOPS-1:0]   o_cnf_hops
);
  // ----------------------------------------
  // Request builder
  // ----------------------------------------
  fcc_pkg::fcc_req_fld_t bst_q;
  fcc_pkg::fcc_req_fld_t bnx;
  logic [7:0]            bcnt_q;
  logic [7:0]            blen;
  logic [7:0]            nrel;
  logic [7:0]            bbyte;
  logic                  bend;
  logic                  req_valid_q;
  logic                  req_last_q;
  logic [7:0]            req_data_q;
  logic [7:0]            sent_flow_q;

  // Over-long route lists are cut, never overrun the relay vector
  assign nrel = (i_relay_cnt > 8'(MAX_HOPS)) ? 8'(MAX_HOPS) : i_relay_cnt;
  assign blen = fcc_pkg::req_len(bst_q, 8'(TS_BYTES), 8'(CLS_BYTES), nrel);
  assign bend = (bcnt_q == blen - 8'h01);
  assign bnx  = fcc_pkg::req_next(bst_q, i_bidir, i_tunnel, nrel); // R05 R17

  always_comb begin
    case (bst_q)
      fcc_pkg::RF_NODE:  bbyte = i_node_id; // R01
      fcc_pkg::RF_FLOW:  bbyte = i_flow_num; // R02
      fcc_pkg::RF_TS:    bbyte = i_traffic_spec[8*bcnt_q +: 8]; // R03
      fcc_pkg::RF_DIR:   bbyte = i_bidir ? fcc_pkg::DIR_BIDIR
                                         : fcc_pkg::DIR_UNI; // R04
      fcc_pkg::RF_RMAC:  bbyte = i_rev_mac[8*bcnt_q +: 8]; // R06
      fcc_pkg::RF_RTS:   bbyte = i_rev_traffic_spec[8*bcnt_q +: 8];
      fcc_pkg::RF_RCLS:  bbyte = i_rev_cls[8*bcnt_q +: 8];
      fcc_pkg::RF_TUN:   bbyte = i_tunnel ? fcc_pkg::TUN_RELAY
                                          : fcc_pkg::TUN_DIRECT; // R07
      fcc_pkg::RF_ENDP:  bbyte = i_endpoint_id; // R08
      fcc_pkg::RF_RCNT:  bbyte = nrel; // R09
      fcc_pkg::RF_RLIST: bbyte = i_relays[8*bcnt_q +: 8]; // R09
      default:           bbyte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bst_q  <= fcc_pkg::RF_IDLE;
      bcnt_q <= 8'h00;
    end else if (bst_q == fcc_pkg::RF_IDLE) begin
      if (i_start) begin
        bst_q <= fcc_pkg::RF_NODE;
      end
    end else if (bend) begin
      bst_q  <= bnx;
      bcnt_q <= 8'h00;
    end else begin
      bcnt_q <= bcnt_q + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      req_valid_q <= 1'b0;
      req_data_q  <= 8'h00;
      req_last_q  <= 1'b0;
      o_busy      <= 1'b0;
      sent_flow_q <= 8'h00;
    end else begin
      req_valid_q <= (bst_q != fcc_pkg::RF_IDLE);
      req_data_q  <= bbyte;
      req_last_q  <= (bst_q != fcc_pkg::RF_IDLE) && bend &&
                     (bnx == fcc_pkg::RF_IDLE);
      o_busy      <= (bst_q == fcc_pkg::RF_IDLE) ? i_start :
                     !(bend && (bnx == fcc_pkg::RF_IDLE));
      if (bst_q == fcc_pkg::RF_IDLE && i_start) begin
        sent_flow_q <= i_flow_num;
      end
    end
  end

  assign lnk.req_valid = req_valid_q;
  assign lnk.req_data  = req_data_q;
  assign lnk.req_last  = req_last_q;

  // ----------------------------------------
  // Confirm parser
  // ----------------------------------------
  fcc_pkg::fcc_cnf_fld_t pst_q;
  fcc_pkg::fcc_cnf_fld_t pnx;
  logic [7:0]            pcnt_q;
  logic [7:0]            plen;
  logic                  pdone;
  logic                  res_bad_q;
  logic [7:0]            d;

  assign d     = lnk.cnf_data;
  assign plen  = (pst_q == fcc_pkg::CF_HOPS) ? o_cnf_hop_count : 8'h01;
  assign pnx   = fcc_pkg::cnf_next(pst_q, d == fcc_pkg::DIR_BIDIR, d); // R17
  assign pdone = (pcnt_q == plen - 8'h01) && (pnx == fcc_pkg::CF_IDLE);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pst_q  <= fcc_pkg::CF_NODE;
      pcnt_q <= 8'h00;
    end else if (lnk.cnf_valid) begin
      if (lnk.cnf_last || pdone) begin
        pst_q  <= fcc_pkg::CF_NODE;
        pcnt_q <= 8'h00;
      end else if (pcnt_q == plen - 8'h01) begin
        pst_q  <= pnx;
        pcnt_q <= 8'h00;
      end else begin
        pcnt_q <= pcnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cnf_node      <= 8'h00;
      o_cnf_flow      <= 8'h00;
      o_cnf_result    <= 8'h00;
      o_cnf_success   <= 1'b0;
      res_bad_q       <= 1'b0;
      o_cnf_bidir     <= 1'b0;
      o_cnf_rev_flow  <= 8'h00;
      o_cnf_tunnel    <= 1'b0;
      o_cnf_hop_count <= 8'h00;
      o_cnf_hops      <= '0;
    end else if (lnk.cnf_valid) begin
      case (pst_q)
        fcc_pkg::CF_NODE: begin
          o_cnf_node      <= d; // R11
          o_cnf_bidir     <= 1'b0;
          o_cnf_rev_flow  <= 8'h00;
          o_cnf_hop_count <= 8'h00;
        end
        fcc_pkg::CF_FLOW:  o_cnf_flow <= d; // R11
        fcc_pkg::CF_RES: begin
          o_cnf_result  <= d;
          o_cnf_success <= (d == fcc_pkg::RES_SUCCESS); // R14
          res_bad_q     <= (d > fcc_pkg::RES_LAST); // R14
        end
        fcc_pkg::CF_DIR:   o_cnf_bidir <= (d == fcc_pkg::DIR_BIDIR); // R15
        fcc_pkg::CF_RFLOW: o_cnf_rev_flow <= d; // R15
        fcc_pkg::CF_TUN:   o_cnf_tunnel <= (d == fcc_pkg::TUN_RELAY);
        fcc_pkg::CF_CNT:   o_cnf_hop_count <= d; // R16
        fcc_pkg::CF_HOPS: begin
          if (pcnt_q < 8'(MAX_HOPS)) begin
            o_cnf_hops[8*pcnt_q +: 8] <= d; // R16
          end
        end
        default: o_cnf_node <= o_cnf_node;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cnf_valid <= 1'b0;
      o_cnf_error <= 1'b0;
      o_cnf_match <= 1'b0;
    end else begin
      o_cnf_valid <= lnk.cnf_valid && (lnk.cnf_last || pdone);
      o_cnf_error <= lnk.cnf_valid && ((lnk.cnf_last != pdone) ||
                     (pdone && res_bad_q));
      // Only the flow number pairs a confirm with the open request
      o_cnf_match <= lnk.cnf_valid && pdone &&
                     (o_cnf_flow == sent_flow_q); // R10
    end
  end
endmodule

// file: fcc_pkg.sv
package fcc_pkg;
  // ----------------------------------------
  // Field sizes
  // ----------------------------------------
  localparam int TS_BYTES  = 8;
  localparam int CLS_BYTES = 4;
  localparam int MAC_BYTES = 6;
  localparam int MAX_HOPS  = 8;
  // ----------------------------------------
  // Byte codes
  // ----------------------------------------
  localparam logic [7:0] DIR_UNI     = 8'h00;
  localparam logic [7:0] DIR_BIDIR   = 8'h01;
  localparam logic [7:0] TUN_DIRECT  = 8'h00;
  localparam logic [7:0] TUN_RELAY   = 8'h01;
  localparam logic [7:0] RES_SUCCESS = 8'h00;
  localparam logic [7:0] RES_LAST    = 8'h06;
  // ----------------------------------------
  // Field walkers
  // ----------------------------------------
  typedef enum logic [11:0] {
    RF_IDLE  = 12'h001,
    RF_NODE  = 12'h002,
    RF_FLOW  = 12'h004,
    RF_TS    = 12'h008,
    RF_DIR   = 12'h010,
    RF_RMAC  = 12'h020,
    RF_RTS   = 12'h040,
    RF_RCLS  = 12'h080,
    RF_TUN   = 12'h100,
    RF_ENDP  = 12'h200,
    RF_RCNT  = 12'h400,
    RF_RLIST = 12'h800
  } fcc_req_fld_t;

  typedef enum logic [8:0] {
    CF_IDLE  = 9'h001,
    CF_NODE  = 9'h002,
    CF_FLOW  = 9'h004,
    CF_RES   = 9'h008,
    CF_DIR   = 9'h010,
    CF_RFLOW = 9'h020,
    CF_TUN   = 9'h040,
    CF_CNT   = 9'h080,
    CF_HOPS  = 9'h100
  } fcc_cnf_fld_t;

  function automatic fcc_req_fld_t req_next(fcc_req_fld_t f, logic bidir,
                                            logic tun, logic [7:0] n);
    case (f)
      RF_NODE: req_next = RF_FLOW;
      RF_FLOW: req_next = RF_TS;
      RF_TS:   req_next = RF_DIR;
      RF_DIR:  req_next = bidir ? RF_RMAC : RF_TUN;
      RF_RMAC: req_next = RF_RTS;
      RF_RTS:  req_next = RF_RCLS;
      RF_RCLS: req_next = RF_TUN;
      RF_TUN:  req_next = tun ? RF_ENDP : RF_IDLE;
      RF_ENDP: req_next = RF_RCNT;
      RF_RCNT: req_next = (n != 8'h00) ? RF_RLIST : RF_IDLE;
      default: req_next = RF_IDLE;
    endcase
  endfunction

  function automatic logic [7:0] req_len(fcc_req_fld_t f, logic [7:0] ts,
                                         logic [7:0] cls, logic [7:0] n);
    case (f)
      RF_TS:    req_len = ts;
      RF_RTS:   req_len = ts;
      RF_RMAC:  req_len = 8'(MAC_BYTES);
      RF_RCLS:  req_len = cls;
      RF_RLIST: req_len = n;
      default:  req_len = 8'h01;
    endcase
  endfunction

  function automatic fcc_cnf_fld_t cnf_next(fcc_cnf_fld_t f, logic bidir,
                                            logic [7:0] n);
    case (f)
      CF_NODE:  cnf_next = CF_FLOW;
      CF_FLOW:  cnf_next = CF_RES;
      CF_RES:   cnf_next = CF_DIR;
      CF_DIR:   cnf_next = bidir ? CF_RFLOW : CF_TUN;
      CF_RFLOW: cnf_next = CF_TUN;
      CF_TUN:   cnf_next = CF_CNT;
      CF_CNT:   cnf_next = (n != 8'h00) ? CF_HOPS : CF_IDLE;
      default:  cnf_next = CF_IDLE;
    endcase
  endfunction
endpackage

// file: fcc_link_if.sv
`timescale 1ns/1ps
interface fcc_link_if;
  // Request stream, originator to endpoint
  logic       req_valid;
  logic [7:0] req_data;
  logic       req_last;
  // Confirm stream, endpoint to originator
  logic       cnf_valid;
  logic [7:0] cnf_data;
  logic       cnf_last;

  modport origin (
    output req_valid, req_data, req_last,
    input  cnf_valid, cnf_data, cnf_last
  );
  modport endpoint (
    input  req_valid, req_data, req_last,
    output cnf_valid, cnf_data, cnf_last
  );
endinterface

// file: fcc_endpoint.sv
`timescale 1ns/1ps
// Behaviour
// R01: Request octet zero is originator node identifier
// R02: Request octet one is originator flow number
// R03: Traffic spec fills octets two to N+1
// R04: Direction byte: 01 bidirectional, 00 one-way
// R05: Reverse fields present only when direction 01
// R06: Reverse destination is a 48-bit MAC
// R07: Tunnel byte: 00 direct, 01 via relays
// R08: Hidden endpoint: tunnel, endpoint id, route list
// R09: Route list: count then relays first-to-last
// R10: Endpoint confirms with status, echoing flow number
// R11: Confirm octets zero, one: node, flow
// R12: Bidirectional confirm carries reverse flow number
// R13: Tunnelled confirm carries per-hop flow list
// R14: Status octet two: 00 success, 01-06 failures
// R15: Direction octet three; reverse flow if 01
// R16: Hop count then hop list, last hop first
// R17: Variable fields found by walking lengths and flags
module fcc_endpoint #(
  parameter int TS_BYTES  = fcc_pkg::TS_BYTES,
  parameter int CLS_BYTES = fcc_pkg::CLS_BYTES,
  parameter int MAX_HOPS  = fcc_pkg::MAX_HOPS
) (
  // Clock and reset
  input  logic                    i_clk,
  input  logic                    i_reset,
  // Link
  fcc_link_if.endpoint            lnk,
  // Request received
  output logic                    o_req_valid,
  output logic                    o_req_error,
  output logic [7:0]              o_req_node,
  output logic [7:0]              o_req_flow,
  output logic [8*TS_BYTES-1:0]   o_req_traffic_spec,
  output logic                    o_req_bidir,
  output logic [47:0]             o_req_rev_mac,
  output logic [8*TS_BYTES-1:0]   o_req_rev_traffic_spec,
  output logic [8*CLS_BYTES-1:0]  o_req_rev_cls,
  output logic                    o_req_tunnel,
  output logic [7:0]              o_req_endpoint,
  output logic [7:0]              o_req_relay_cnt,
  output logic [8*MAX_HOPS-1:0]   o_req_relays,
  // Confirm to send
  input  logic                    i_rsp_start,
  input  logic [7:0]              i_rsp_result,
  input  logic [7:0]              i_rsp_rev_flow,
  input  logic [7:0]              i_rsp_hop_cnt,
  input  logic [8*MAX_HOPS-1:0]   i_rsp_hops,
  output logic                    o_rsp_pending,
  output logic                    o_busy
);
  // ----------------------------------------
  // Request parser
  // ----------------------------------------
  fcc_pkg::fcc_req_fld_t pst_q;
  fcc_pkg::fcc_req_fld_t pnx;
  logic [7:0]            pcnt_q;
  logic [7:0]            plen;
  logic                  pend;
  logic                  pdone;
  logic [7:0]            d;

  assign d     = lnk.req_data;
  assign plen  = fcc_pkg::req_len(pst_q, 8'(TS_BYTES), 8'(CLS_BYTES),
                                  o_req_relay_cnt);
  assign pend  = (pcnt_q == plen - 8'h01);
  assign pnx   = fcc_pkg::req_next(pst_q, d == fcc_pkg::DIR_BIDIR,
                                   d == fcc_pkg::TUN_RELAY, d); // R05 R17
  assign pdone = pend && (pnx == fcc_pkg::RF_IDLE);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pst_q  <= fcc_pkg::RF_NODE;
      pcnt_q <= 8'h00;
    end else if (lnk.req_valid) begin
      // A short or long frame restarts the walk at the next byte
      if (lnk.req_last || pdone) begin
        pst_q  <= fcc_pkg::RF_NODE;
        pcnt_q <= 8'h00;
      end else if (pend) begin
        pst_q  <= pnx; // R17
        pcnt_q <= 8'h00;
      end else begin
        pcnt_q <= pcnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_req_node      <= 8'h00;
      o_req_flow      <= 8'h00;
      o_req_traffic_spec     <= '0;
      o_req_bidir     <= 1'b0;
      o_req_rev_mac   <= '0;
      o_req_rev_traffic_spec <= '0;
      o_req_rev_cls   <= '0;
      o_req_tunnel    <= 1'b0;
      o_req_endpoint  <= 8'h00;
      o_req_relay_cnt <= 8'h00;
      o_req_relays    <= '0;
    end else if (lnk.req_valid) begin
      case (pst_q)
        fcc_pkg::RF_NODE: begin
          o_req_node      <= d; // R01
          o_req_bidir     <= 1'b0;
          o_req_tunnel    <= 1'b0;
          o_req_endpoint  <= 8'h00;
          o_req_relay_cnt <= 8'h00;
        end
        fcc_pkg::RF_FLOW: o_req_flow <= d; // R02
        fcc_pkg::RF_TS:   o_req_traffic_spec[8*pcnt_q +: 8] <= d; // R03
        fcc_pkg::RF_DIR:  o_req_bidir <= (d == fcc_pkg::DIR_BIDIR); // R04
        fcc_pkg::RF_RMAC: o_req_rev_mac[8*pcnt_q +: 8] <= d; // R06
        fcc_pkg::RF_RTS:  o_req_rev_traffic_spec[8*pcnt_q +: 8] <= d; // R05
        fcc_pkg::RF_RCLS: o_req_rev_cls[8*pcnt_q +: 8] <= d; // R05
        fcc_pkg::RF_TUN:  o_req_tunnel <= (d == fcc_pkg::TUN_RELAY); // R07
        fcc_pkg::RF_ENDP: o_req_endpoint <= d; // R08
        fcc_pkg::RF_RCNT: o_req_relay_cnt <= d; // R09
        fcc_pkg::RF_RLIST: begin
          if (pcnt_q < 8'(MAX_HOPS)) begin
            o_req_relays[8*pcnt_q +: 8] <= d; // R09
          end
        end
        default: o_req_node <= o_req_node;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_req_valid <= 1'b0;
      o_req_error <= 1'b0;
    end else begin
      o_req_valid <= lnk.req_valid && (lnk.req_last || pdone);
      o_req_error <= lnk.req_valid && (lnk.req_last != pdone);
    end
  end

  // ----------------------------------------
  // Confirm builder
  // ----------------------------------------
  fcc_pkg::fcc_cnf_fld_t bst_q;
  fcc_pkg::fcc_cnf_fld_t bnx;
  logic [7:0]            bcnt_q;
  logic [7:0]            blen;
  logic [7:0]            nhop;
  logic [7:0]            bbyte;
  logic                  bend;
  logic                  go;
  logic                  cnf_valid_q;
  logic                  cnf_last_q;
  logic [7:0]            cnf_data_q;

  // Hop list only for tunnelled flows, cut to the vector size
  assign nhop = !o_req_tunnel ? 8'h00 :
                (i_rsp_hop_cnt > 8'(MAX_HOPS)) ? 8'(MAX_HOPS) :
                i_rsp_hop_cnt; // R13
  assign blen = (bst_q == fcc_pkg::CF_HOPS) ? nhop : 8'h01;
  assign bend = (bcnt_q == blen - 8'h01);
  assign bnx  = fcc_pkg::cnf_next(bst_q, o_req_bidir, nhop); // R12 R17
  assign go   = (bst_q == fcc_pkg::CF_IDLE) && i_rsp_start && o_rsp_pending;

  always_comb begin
    case (bst_q)
      fcc_pkg::CF_NODE:  bbyte = o_req_node; // R11
      fcc_pkg::CF_FLOW:  bbyte = o_req_flow; // R10 R11
      fcc_pkg::CF_RES:   bbyte = i_rsp_result; // R10 R14
      fcc_pkg::CF_DIR:   bbyte = o_req_bidir ? fcc_pkg::DIR_BIDIR
                                             : fcc_pkg::DIR_UNI; // R15
      fcc_pkg::CF_RFLOW: bbyte = i_rsp_rev_flow; // R12
      fcc_pkg::CF_TUN:   bbyte = o_req_tunnel ? fcc_pkg::TUN_RELAY
                                              : fcc_pkg::TUN_DIRECT;
      fcc_pkg::CF_CNT:   bbyte = nhop; // R16
      fcc_pkg::CF_HOPS:  bbyte = i_rsp_hops[8*bcnt_q +: 8]; // R16
      default:           bbyte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bst_q  <= fcc_pkg::CF_IDLE;
      bcnt_q <= 8'h00;
    end else if (bst_q == fcc_pkg::CF_IDLE) begin
      if (go) begin
        bst_q <= fcc_pkg::CF_NODE;
      end
    end else if (bend) begin
      bst_q  <= bnx;
      bcnt_q <= 8'h00;
    end else begin
      bcnt_q <= bcnt_q + 8'h01;
    end
  end

  // A good request arms one confirm; a new request wins over a start
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rsp_pending <= 1'b0;
    end else if (lnk.req_valid && pdone && lnk.req_last) begin
      o_rsp_pending <= 1'b1; // R10
    end else if (go) begin
      o_rsp_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnf_valid_q <= 1'b0;
      cnf_data_q  <= 8'h00;
      cnf_last_q  <= 1'b0;
      o_busy      <= 1'b0;
    end else begin
      cnf_valid_q <= (bst_q != fcc_pkg::CF_IDLE);
      cnf_data_q  <= bbyte;
      cnf_last_q  <= (bst_q != fcc_pkg::CF_IDLE) && bend &&
                     (bnx == fcc_pkg::CF_IDLE);
      o_busy      <= (bst_q == fcc_pkg::CF_IDLE) ? go :
                     !(bend && (bnx == fcc_pkg::CF_IDLE));
    end
  end

  assign lnk.cnf_valid = cnf_valid_q;
  assign lnk.cnf_data  = cnf_data_q;
  assign lnk.cnf_last  = cnf_last_q;
endmodule

// file: fcc_link_sva.sv
`timescale 1ns/1ps
module fcc_link_sva (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_reset,
  // Link
  input wire logic       req_valid,
  input wire logic [7:0] req_data,
  input wire logic       req_last,
  input wire logic       cnf_valid,
  input wire logic [7:0] cnf_data,
  input wire logic       cnf_last
);
  // ----------------------------------------
  // Octet tracking
  // ----------------------------------------
  localparam int TS = fcc_pkg::TS_BYTES;
  localparam int CL = fcc_pkg::CLS_BYTES;
  logic [7:0] rc_q;
  logic [7:0] cc_q;
  logic [7:0] nd_q;
  logic [7:0] fl_q;
  logic [7:0] dir_q;
  logic [7:0] tun_at;
  // Tunnel octet moves with the reverse block
  assign tun_at = (dir_q == 8'h01) ? 8'(2*TS+CL+9) : 8'(TS+3);
  always_ff @(posedge i_clk) begin
    if (i_reset || (req_valid && req_last)) rc_q <= 8'h00;
    else if (req_valid) rc_q <= rc_q + 8'h01;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset || (cnf_valid && cnf_last)) cc_q <= 8'h00;
    else if (cnf_valid) cc_q <= cc_q + 8'h01;
  end
  // Echo fields of the latest request
  always_ff @(posedge i_clk) begin
    if (i_reset) nd_q <= 8'h00;
    else if (req_valid && rc_q == 8'h00) nd_q <= req_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) fl_q <= 8'h00;
    else if (req_valid && rc_q == 8'h01) fl_q <= req_data;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) dir_q <= 8'h00;
    else if (req_valid && rc_q == 8'(TS+2)) dir_q <= req_data;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  req_frame_gap_a: assert property (
    req_valid && req_last |=> !req_valid)
    else $error("request frames not separated");
  req_burst_a: assert property (req_valid && !req_last |=> req_valid)
    else $error("request frame has a hole");
  req_min_len_a: assert property (
    req_valid && req_last |-> rc_q >= 8'(TS+3))
    else $error("request frame too short");
  req_dir_code_a: assert property (
    req_valid && rc_q == 8'(TS+2) |-> req_data <= 8'h01)
    else $error("direction byte not 00 or 01");
  req_tun_code_a: assert property (
    req_valid && rc_q == tun_at |-> req_data <= 8'h01)
    else $error("tunnel byte not 00 or 01");
  cnf_burst_a: assert property (cnf_valid && !cnf_last |=> cnf_valid)
    else $error("confirm frame has a hole");
  cnf_node_echo_a: assert property (
    cnf_valid && cc_q == 8'h00 |-> cnf_data == nd_q)
    else $error("confirm node not echoed");
  cnf_flow_echo_a: assert property (
    cnf_valid && cc_q == 8'h01 |-> cnf_data == fl_q)
    else $error("confirm flow not echoed");
  cnf_dir_echo_a: assert property (
    cnf_valid && cc_q == 8'h03 |-> cnf_data == dir_q)
    else $error("confirm direction differs");
  cover property (req_valid && rc_q == 8'(TS+2) && req_data == 8'h01);
  cover property (req_valid && rc_q == tun_at && req_data == 8'h01);
  cover property (cnf_valid && cnf_last && cc_q > 8'h06);
endmodule

// file: flow_origination_message_codec_bench.sv
`timescale 1ns/1ps
module flow_origination_message_codec_bench;
  // ----------------------------------------
  // Stimulus and expectations
  // ----------------------------------------
  localparam int TS = fcc_pkg::TS_BYTES;
  localparam int CL = fcc_pkg::CLS_BYTES;
  localparam int MH = fcc_pkg::MAX_HOPS;
  typedef struct packed {
    logic [7:0]      nd, fl, ep, rc, res, rfl, hc;
    logic            bd, tn;
    logic [8*TS-1:0] ts, rts;
    logic [47:0]     mac;
    logic [8*CL-1:0] cls;
    logic [8*MH-1:0] rl, hp;
  } fcc_stim_t;
  fcc_stim_t       s, e, f;
  fcc_stim_t       qr[$], qc[$];
  logic            i_clk = 1'b0;
  logic            i_reset = 1'b1;
  logic [31:0]     sd = 32'h0ad2ba35;
  logic [31:0]     r;
  logic [351:0]    w;
  int              n_mismatch = 0;
  int              samples_checked = 0;
  logic            rv, re, rb, rt, rp, eb, ob, cv, ce, cm, cs, cb, ct, st, rs;
  logic [7:0]      rn, rf, rep, rrc, cn, cf, cr, crf, chc, h;
  logic [8*TS-1:0] rts_o, rrts;
  logic [47:0]     rmac;
  logic [8*CL-1:0] rcls;
  logic [8*MH-1:0] rrl, chp;

  always #2.5 i_clk = ~i_clk;

  fcc_link_if lnk ();
  fcc_originator i_fcc_originator (
    .i_clk(i_clk), .i_reset(i_reset), .lnk(lnk), .i_start(st),
    .i_node_id(s.nd), .i_flow_num(s.fl), .i_traffic_spec(s.ts), .i_bidir(s.bd),
    .i_rev_mac(s.mac), .i_rev_traffic_spec(s.rts), .i_rev_cls(s.cls),
    .i_tunnel(s.tn), .i_endpoint_id(s.ep), .i_relay_cnt(s.rc),
    .i_relays(s.rl), .o_busy(ob), .o_cnf_valid(cv), .o_cnf_error(ce),
    .o_cnf_match(cm), .o_cnf_success(cs), .o_cnf_node(cn),
    .o_cnf_flow(cf), .o_cnf_result(cr), .o_cnf_bidir(cb),
    .o_cnf_rev_flow(crf), .o_cnf_tunnel(ct), .o_cnf_hop_count(chc),
    .o_cnf_hops(chp));
  fcc_endpoint i_fcc_endpoint (
    .i_clk(i_clk), .i_reset(i_reset), .lnk(lnk), .o_req_valid(rv),
    .o_req_error(re), .o_req_node(rn), .o_req_flow(rf),
    .o_req_traffic_spec(rts_o), .o_req_bidir(rb), .o_req_rev_mac(rmac),
    .o_req_rev_traffic_spec(rrts), .o_req_rev_cls(rcls), .o_req_tunnel(rt),
    .o_req_endpoint(rep), .o_req_relay_cnt(rrc), .o_req_relays(rrl),
    .i_rsp_start(rs), .i_rsp_result(s.res), .i_rsp_rev_flow(s.rfl),
    .i_rsp_hop_cnt(s.hc), .i_rsp_hops(s.hp), .o_rsp_pending(rp),
    .o_busy(eb));
  fcc_link_sva i_fcc_link_sva (
    .i_clk(i_clk), .i_reset(i_reset), .req_valid(lnk.req_valid),
    .req_data(lnk.req_data), .req_last(lnk.req_last),
    .cnf_valid(lnk.cnf_valid), .cnf_data(lnk.cnf_data),
    .cnf_last(lnk.cnf_last));

  function automatic logic [31:0] rnd();
    sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
    return sd;
  endfunction
  // Bytes past the count hold stale data
  function automatic logic [63:0] msk(logic [7:0] n);
    logic [64:0] m;
    m = (65'h1 << (8 * n)) - 65'h1;
    return m[63:0];
  endfunction
  task automatic chk(string n, logic [63:0] x, logic [63:0] g);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    s = '0;
    st = 1'b0;
    rs = 1'b0;
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      {s.nd, s.fl, s.ep, s.rfl} = r;
      r = rnd();
      s.bd = r[0];
      // First two frames pin the relay count to its bounds
      s.tn = r[1] | (k < 2);
      s.rc = (k < 2) ? 8'(8 * k) : 8'(r[7:4] % 4'd9);
      s.hc = 8'(r[11:8] % 4'd9);
      // Code 07 is past the last failure code and must be flagged
      s.res = 8'(k % 8);
      for (int i = 0; i < 11; i++) w = {w[319:0], rnd()};
      {s.ts, s.rts, s.mac, s.cls, s.rl, s.hp} = w[335:0];
      st = 1'b1;
      qr.push_back(s);
      @(negedge i_clk);
      st = 1'b0;
      chk("org_busy", 64'h1, ob);
      for (int i = 0; i < 100 && rp !== 1'b1; i++) @(negedge i_clk);
      chk("pending", 64'h1, rp);
      rs = 1'b1;
      qc.push_back(s);
      @(negedge i_clk);
      rs = 1'b0;
      chk("ept_busy", 64'h1, eb);
      chk("pending_clr", 64'h0, rp);
      for (int i = 0; i < 100 && eb !== 1'b0; i++) @(negedge i_clk);
      chk("ept_idle", 64'h0, eb);
      repeat (3) @(negedge i_clk);
    end
    chk("queues", 64'h0, 64'(qr.size() + qc.size()));
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(negedge i_clk) begin
    if (rv === 1'b1) begin
      e = qr.pop_front();
      chk("req_error", 64'h0, re);
      chk("org_idle", 64'h0, ob);
      chk("node", e.nd, rn);
      chk("flow", e.fl, rf);
      chk("traffic_spec", e.ts, rts_o);
      chk("bidir", e.bd, rb);
      if (e.bd) begin
        chk("rev_mac", e.mac, rmac);
        chk("rev_traffic_spec", e.rts, rrts);
        chk("rev_cls", e.cls, rcls);
      end
      chk("tunnel", e.tn, rt);
      if (e.tn) begin
        chk("endpoint", e.ep, rep);
        chk("relay_cnt", e.rc, rrc);
        chk("relays", e.rl & msk(e.rc), rrl & msk(e.rc));
      end
    end
    if (cv === 1'b1) begin
      f = qc.pop_front();
      h = f.tn ? f.hc : 8'h00;
      chk("cnf_error", 64'(f.res > fcc_pkg::RES_LAST), ce);
      chk("match", 64'h1, cm);
      chk("cnf_node", f.nd, cn);
      chk("cnf_flow", f.fl, cf);
      chk("result", f.res, cr);
      chk("success", f.res == 8'h00, cs);
      chk("cnf_bidir", f.bd, cb);
      if (f.bd) chk("rev_flow", f.rfl, crf);
      chk("cnf_tunnel", f.tn, ct);
      chk("hop_cnt", h, chc);
      chk("hops", f.hp & msk(h), chp & msk(h));
    end
  end
endmodule
